// >>> src/core_sfr_bank.sv
`timescale 1ns/1ns
module core_sfr_bank #(
  parameter int NUM_BANKS  = 11,
  parameter int BANK_BYTES = 192
) (
  input  logic                  clk,
  input  logic                  rst,
  input  logic                  power_up,
  input  logic                  acc_valid,
  input  logic                  acc_write,
  input  logic [7:0]            acc_addr,
  input  logic [7:0]            acc_wdata,
  output logic [7:0]            rd_data,
  output logic                  rd_valid,
  input  logic                  alu_valid,
  input  core_sfr_pkg::alu_op_t alu_op,
  input  logic [7:0]            alu_operand,
  output logic [7:0]            accumulator,
  output logic [7:0]            flag_register,
  output logic [7:0]            bank_select,
  input  logic [7:0]            pc_low_in,
  output logic                  pc_load,
  output logic [7:0]            pc_low_out,
  output logic                  dummy_cycle,
  input  logic                  tbl_read,
  input  logic [7:0]            tbl_dest,
  output logic                  prog_req,
  output logic [7:0]            prog_addr,
  input  logic                  prog_valid,
  input  logic [15:0]           prog_data,
  input  logic                  halt_exec,
  input  logic                  wdt_clear_exec,
  input  logic                  wdt_tick,
  output logic                  wdt_reset_req,
  input  logic                  int_entry,
  input  logic                  return_from_interrupt_exec,
  output logic                  master_interrupt_enable,
  output logic [7:0]            port_a_direction,
  output logic [7:0]            port_c_direction,
  output logic [7:0]            port_d_direction,
  output logic [7:0]            port_e_direction,
  output logic [7:0]            port_f_direction
);
  import core_sfr_pkg::*;

  // ****************************************
  // state
  // ****************************************
  logic [7:0]    first_pointer;
  logic [7:0]    second_pointer;
  logic [7:0]    table_pointer;
  logic [7:0]    table_high_byte;
  logic [7:0]    watchdog_prescale;
  logic [7:0]    int_ctrl0;
  logic [7:0]    int_ctrl1;
  logic [7:0]    timer_lo [NUM_TIMERS];
  logic [7:0]    timer_hi [NUM_TIMERS];
  logic [7:0]    timer_ct [NUM_TIMERS];
  logic [WD_PRE_W-1:0] wd_pre;
  logic [WD_CNT_W-1:0] wd_cnt;
  logic          wd_caused;
  logic          rst_prev;
  tbl_state_t    tbl_state;
  logic [7:0]    tbl_dest_q;
  logic [7:0]    next_flags;
  logic [7:0]    next_acc;
  logic [7:0]    sfr_rd;

  ram_port_if ram ();

  gpr_ram #(
    .NUM_BANKS  (NUM_BANKS),
    .BANK_BYTES (BANK_BYTES)
  ) u_ram (
    .clk  (clk),
    .port (ram)
  );

  // ****************************************
  // request merge and address decode
  // ****************************************
  wire       tbl_store = (tbl_state == TBL_WAIT) && prog_valid;
  wire       req_w     = tbl_store ? 1'b1 : (acc_valid && acc_write);
  // low table byte goes to the named location
  wire [7:0] req_addr  = tbl_store ? tbl_dest_q : acc_addr;
  wire [7:0] req_data  = tbl_store ? prog_data[7:0] : acc_wdata;

  // direct addresses stay in bank 0
  wire       via_first  = (req_addr == ADDR_FIRST_IND);
  wire       via_second = (req_addr == ADDR_SECOND_IND);
  wire [7:0] tgt_addr   = via_first  ? first_pointer :
                          via_second ? second_pointer : req_addr;
  // first pointer forced to bank 0
  // second pointer takes the selected bank
  wire [7:0] tgt_bank   = via_second ? bank_select : BANK_ZERO;
  // low area is the same in every bank
  wire       sfr_hit    = tgt_addr < SFR_LIMIT;
  // indirect access onto an indirect location is void
  wire       self_ind   = (via_first || via_second) &&
                          (tgt_addr == ADDR_FIRST_IND ||
                           tgt_addr == ADDR_SECOND_IND);
  // undefined bank values map to nothing
  wire       bad_bank   = !sfr_hit && (tgt_bank > LAST_BANK);
  wire       blocked    = self_ind || bad_bank;
  wire       wr_sfr     = req_w && !blocked && sfr_hit;

  wire wr_first_ptr  = wr_sfr && tgt_addr == ADDR_FIRST_PTR;
  wire wr_second_ptr = wr_sfr && tgt_addr == ADDR_SECOND_PTR;
  wire wr_bank_sel   = wr_sfr && tgt_addr == ADDR_BANK_SEL;
  wire wr_accum      = wr_sfr && tgt_addr == ADDR_ACCUM;
  wire wr_pc_low     = wr_sfr && tgt_addr == ADDR_PC_LOW;
  wire wr_table_ptr  = wr_sfr && tgt_addr == ADDR_TABLE_PTR;
  wire wr_prescale   = wr_sfr && tgt_addr == ADDR_WD_PRESCALE;
  wire wr_flags      = wr_sfr && tgt_addr == ADDR_FLAGS;
  wire wr_int0       = wr_sfr && tgt_addr == ADDR_INT_CTRL0;
  wire wr_int1       = wr_sfr && tgt_addr == ADDR_INT_CTRL1;
  wire wr_dir_a      = wr_sfr && tgt_addr == ADDR_PORT_A_DIR;
  wire wr_dir_c      = wr_sfr && tgt_addr == ADDR_PORT_C_DIR;
  wire wr_dir_d      = wr_sfr && tgt_addr == ADDR_PORT_D_DIR;
  wire wr_dir_e      = wr_sfr && tgt_addr == ADDR_PORT_E_DIR;
  wire wr_dir_f      = wr_sfr && tgt_addr == ADDR_PORT_F_DIR;

  // bank value picks the general-purpose bank
  assign ram.we     = req_w && !blocked && !sfr_hit;
  assign ram.bank   = tgt_bank[3:0];
  assign ram.offset = 8'(tgt_addr - SFR_LIMIT);
  assign ram.wdata  = req_data;

  // ****************************************
  // special register read mux
  // ****************************************
  always_comb begin
    sfr_rd = READ_ZERO;
    case (tgt_addr)
      ADDR_FIRST_PTR:   sfr_rd = first_pointer;
      ADDR_SECOND_PTR:  sfr_rd = second_pointer;
      ADDR_BANK_SEL:    sfr_rd = bank_select;
      ADDR_ACCUM:       sfr_rd = accumulator;
      ADDR_PC_LOW:      sfr_rd = pc_low_in;
      ADDR_TABLE_PTR:   sfr_rd = table_pointer;
      ADDR_TABLE_HIGH:  sfr_rd = table_high_byte;
      ADDR_WD_PRESCALE: sfr_rd = watchdog_prescale;
      ADDR_FLAGS:       sfr_rd = flag_register;
      ADDR_INT_CTRL0:   sfr_rd = int_ctrl0;
      ADDR_INT_CTRL1:   sfr_rd = int_ctrl1;
      ADDR_PORT_A_DIR:  sfr_rd = port_a_direction;
      ADDR_PORT_C_DIR:  sfr_rd = port_c_direction;
      ADDR_PORT_D_DIR:  sfr_rd = port_d_direction;
      ADDR_PORT_E_DIR:  sfr_rd = port_e_direction;
      ADDR_PORT_F_DIR:  sfr_rd = port_f_direction;
      default:          sfr_rd = READ_ZERO;
    endcase
    for (int i = 0; i < NUM_TIMERS; i++) begin
      if (tgt_addr == TIMER_LO_ADDR[i]) sfr_rd = timer_lo[i];
      if (tgt_addr == TIMER_HI_ADDR[i]) sfr_rd = timer_hi[i];
      if (tgt_addr == TIMER_CT_ADDR[i]) sfr_rd = timer_ct[i];
    end
  end

  wire [7:0] rd_mux = blocked ? READ_ZERO :
                      sfr_hit ? sfr_rd : ram.rdata;

  // read answer one cycle after the request
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_valid <= 1'b0;
      rd_data  <= READ_ZERO;
    end else begin
      rd_valid <= acc_valid && !acc_write && !tbl_store;
      rd_data  <= rd_mux;
    end
  end

  // ****************************************
  // alu and flags
  // ****************************************
  wire       is_sub = (alu_op == OP_SUB);
  wire [7:0] b_in   = is_sub ? ~alu_operand : alu_operand;
  wire [8:0] sum9   = {1'b0, accumulator} + {1'b0, b_in} + {8'h00, is_sub};
  wire [4:0] half5  = {1'b0, accumulator[3:0]} + {1'b0, b_in[3:0]} +
                      {4'h0, is_sub};
  wire [7:0] low8   = {1'b0, accumulator[6:0]} + {1'b0, b_in[6:0]} +
                      {7'h00, is_sub};
  wire       carry  = flag_register[FLAG_CARRY];

  // low 3 bits give ratio 1 to 128
  wire [WD_PRE_W-1:0] wd_mask =
    WD_PRE_W'((8'h01 << watchdog_prescale[2:0]) - 8'h01);
  wire wd_div_tick = wdt_tick && ((wd_pre & wd_mask) == wd_mask);
  wire wd_overflow = wd_div_tick && (&wd_cnt);

  always_comb begin
    next_acc   = accumulator;
    next_flags = flag_register;
    // software reaches only the arithmetic flags
    if (wr_flags) begin
      next_flags = (flag_register & ~FLAGS_WRITE_MASK) |
                   (req_data & FLAGS_WRITE_MASK);
    end
    if (wr_accum) next_acc = req_data;
    if (alu_valid) begin
      case (alu_op)
        OP_ADD, OP_SUB: begin
          next_acc = sum9[7:0];
          next_flags[FLAG_CARRY] = sum9[8];
          // nibble carry, or no nibble borrow
          next_flags[FLAG_HALF]  = half5[4];
          // carry into msb differs from carry out
          next_flags[FLAG_OVER]  = low8[7] ^ sum9[8];
        end
        OP_AND:  next_acc = accumulator & alu_operand;
        OP_OR:   next_acc = accumulator | alu_operand;
        OP_XOR:  next_acc = accumulator ^ alu_operand;
        OP_RLC: begin
          next_acc = {accumulator[6:0], carry};
          next_flags[FLAG_CARRY] = accumulator[7];
        end
        OP_RRC: begin
          next_acc = {carry, accumulator[7:1]};
          next_flags[FLAG_CARRY] = accumulator[0];
        end
        default: next_acc = alu_operand;
      endcase
      // zero test on arithmetic and logic results
      if (alu_op != OP_RLC && alu_op != OP_RRC && alu_op != OP_PASS) begin
        next_flags[FLAG_ZERO] = (next_acc == READ_ZERO);
      end
    end
    if (halt_exec) next_flags[FLAG_PWR_DOWN] = 1'b1;
    else if (wdt_clear_exec) next_flags[FLAG_PWR_DOWN] = 1'b0;
    // timeout sets and wins over clear or halt
    if (wd_overflow) next_flags[FLAG_TIMEOUT] = 1'b1;
    else if (wdt_clear_exec || halt_exec) next_flags[FLAG_TIMEOUT] = 1'b0;
    next_flags[7:6] = 2'b00;
  end

  // flags live only here, nothing stacks them
  always_ff @(posedge clk) begin
    if (rst && power_up) begin
      flag_register <= READ_ZERO;
    end else if (rst) begin
      // warm reset keeps the two system flags
      flag_register <= flag_register & FLAGS_KEEP_MASK;
    end else begin
      flag_register <= next_flags;
    end
  end

  // ****************************************
  // watchdog divider and counter
  // ****************************************
  // prescaler feeds counter; clear restarts both
  always_ff @(posedge clk) begin
    if (rst || wdt_clear_exec) begin
      wd_pre <= '0;
      wd_cnt <= '0;
    end else begin
      if (wdt_tick) wd_pre <= wd_pre + 1'b1;
      if (wd_div_tick) wd_cnt <= wd_cnt + 1'b1;
    end
  end

  // remembers the cause across the reset it triggers
  always_ff @(posedge clk) begin
    rst_prev <= rst;
    if (rst && power_up) wd_caused <= 1'b0;
    else if (wd_overflow) wd_caused <= 1'b1;
    else if (rst_prev && !rst) wd_caused <= 1'b0;
    wdt_reset_req <= !rst && wd_overflow;
  end

  // ****************************************
  // plain control registers
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      // keep bank only after watchdog reset in halt
      if (!(wd_caused && flag_register[FLAG_PWR_DOWN])) begin
        bank_select <= BANK_ZERO;
      end
      first_pointer     <= READ_ZERO;
      second_pointer    <= READ_ZERO;
      table_pointer     <= READ_ZERO;
      watchdog_prescale <= WD_PRESCALE_RST;
      accumulator       <= READ_ZERO;
    end else begin
      if (wr_bank_sel)   bank_select       <= req_data;
      if (wr_first_ptr)  first_pointer     <= req_data;
      if (wr_second_ptr) second_pointer    <= req_data;
      if (wr_table_ptr)  table_pointer     <= req_data;
      if (wr_prescale)   watchdog_prescale <= req_data;
      accumulator <= next_acc;
    end
  end

  // 1 makes an input; two port c bits absent
  always_ff @(posedge clk) begin
    if (rst) begin
      port_a_direction <= DIR_RESET;
      port_c_direction <= DIR_RESET & PORT_C_DIR_MASK;
      port_d_direction <= DIR_RESET;
      port_e_direction <= DIR_RESET;
      port_f_direction <= DIR_RESET;
    end else begin
      if (wr_dir_a) port_a_direction <= req_data;
      if (wr_dir_c) port_c_direction <= req_data & PORT_C_DIR_MASK;
      if (wr_dir_d) port_d_direction <= req_data;
      if (wr_dir_e) port_e_direction <= req_data;
      if (wr_dir_f) port_f_direction <= req_data;
    end
  end

  // entry clears, return sets, return wins
  wire next_master = return_from_interrupt_exec ? 1'b1 :
                     int_entry ? 1'b0 :
                     wr_int0   ? req_data[MASTER_EN_BIT] :
                     int_ctrl0[MASTER_EN_BIT];

  always_ff @(posedge clk) begin
    if (rst) begin
      int_ctrl0 <= READ_ZERO;
      int_ctrl1 <= READ_ZERO;
    end else begin
      if (wr_int0) int_ctrl0 <= req_data;
      int_ctrl0[MASTER_EN_BIT] <= next_master;
      if (wr_int1) int_ctrl1 <= req_data;
    end
  end
  assign master_interrupt_enable = int_ctrl0[MASTER_EN_BIT];

  // three timer byte pairs and controls
  for (genvar t = 0; t < NUM_TIMERS; t++) begin : g_timer
    always_ff @(posedge clk) begin
      if (rst) begin
        timer_lo[t] <= READ_ZERO;
        timer_hi[t] <= READ_ZERO;
        timer_ct[t] <= READ_ZERO;
      end else if (wr_sfr) begin
        if (tgt_addr == TIMER_LO_ADDR[t]) timer_lo[t] <= req_data;
        if (tgt_addr == TIMER_HI_ADDR[t]) timer_hi[t] <= req_data;
        if (tgt_addr == TIMER_CT_ADDR[t]) timer_ct[t] <= req_data;
      end
    end
  end

  // ****************************************
  // program counter low and table read
  // ****************************************
  // in-page jump plus one dummy cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      pc_load     <= 1'b0;
      dummy_cycle <= 1'b0;
      pc_low_out  <= READ_ZERO;
    end else begin
      pc_load     <= wr_pc_low;
      dummy_cycle <= wr_pc_low;
      if (wr_pc_low) pc_low_out <= req_data;
    end
  end

  // fetch at table pointer, keep high byte
  always_ff @(posedge clk) begin
    if (rst) begin
      tbl_state       <= TBL_IDLE;
      prog_req        <= 1'b0;
      prog_addr       <= READ_ZERO;
      tbl_dest_q      <= READ_ZERO;
      table_high_byte <= READ_ZERO;
    end else begin
      case (tbl_state)
        TBL_IDLE: if (tbl_read) begin
          tbl_state  <= TBL_WAIT;
          prog_req   <= 1'b1;
          prog_addr  <= table_pointer;
          tbl_dest_q <= tbl_dest;
        end
        TBL_WAIT: if (prog_valid) begin
          tbl_state       <= TBL_IDLE;
          prog_req        <= 1'b0;
          table_high_byte <= prog_data[15:8];
        end
        default: tbl_state <= TBL_IDLE;
      endcase
    end
  end
endmodule

// >>> src/core_sfr_pkg.sv
// Overview of operation
// - eleven banks, chosen by bank select value
// - first pointer path always reaches bank 0
// - reset clears bank, except watchdog-in-halt reset
// - special registers visible from every bank
// - direct addresses always go to bank 0
// - program counter low write jumps, adds dummy
// - table read: high byte kept, low stored
// - low 3 prescale bits divide watchdog, overflow resets
// - flag writes never touch timeout/power-down flags
// - carry from add, no-borrow, rotate through carry
// - half carry from low nibble carry/borrow
// - zero flag set on zero add/sub/logic result; rotates and pass leave it
// - overflow flag is carry-in xor carry-out of msb
// - power-down: halt sets, power-up/watchdog clear clears
// - timeout: timeout sets, power-up/clear/halt clear it
// - flags are never stacked on calls/interrupts
// - master enable cleared on entry, set on return
// - direction 1 input, 0 output; two bits absent
// - three 16-bit timers as byte pairs plus control
// - alu results go to accumulator only
// - second pointer uses bank; self-pointing reads zero
// - unused special locations read zero
package core_sfr_pkg;

  // ****************************************
  // map of the special register area
  // ****************************************
  localparam logic [7:0] SFR_LIMIT        = 8'h40;
  localparam logic [7:0] ADDR_FIRST_IND   = 8'h00;
  localparam logic [7:0] ADDR_FIRST_PTR   = 8'h01;
  localparam logic [7:0] ADDR_SECOND_IND  = 8'h02;
  localparam logic [7:0] ADDR_SECOND_PTR  = 8'h03;
  localparam logic [7:0] ADDR_BANK_SEL    = 8'h04;
  localparam logic [7:0] ADDR_ACCUM       = 8'h05;
  localparam logic [7:0] ADDR_PC_LOW      = 8'h06;
  localparam logic [7:0] ADDR_TABLE_PTR   = 8'h07;
  localparam logic [7:0] ADDR_TABLE_HIGH  = 8'h08;
  localparam logic [7:0] ADDR_WD_PRESCALE = 8'h09;
  localparam logic [7:0] ADDR_FLAGS       = 8'h0A;
  localparam logic [7:0] ADDR_INT_CTRL0   = 8'h0B;
  localparam logic [7:0] ADDR_INT_CTRL1   = 8'h1E;
  localparam logic [7:0] ADDR_PORT_A_DIR  = 8'h13;
  localparam logic [7:0] ADDR_PORT_C_DIR  = 8'h17;
  localparam logic [7:0] ADDR_PORT_D_DIR  = 8'h19;
  localparam logic [7:0] ADDR_PORT_E_DIR  = 8'h1B;
  localparam logic [7:0] ADDR_PORT_F_DIR  = 8'h35;
  localparam int         NUM_TIMERS       = 3;
  localparam logic [7:0] TIMER_HI_ADDR [NUM_TIMERS] = '{8'h0C, 8'h0F, 8'h38};
  localparam logic [7:0] TIMER_LO_ADDR [NUM_TIMERS] = '{8'h0D, 8'h10, 8'h39};
  localparam logic [7:0] TIMER_CT_ADDR [NUM_TIMERS] = '{8'h0E, 8'h11, 8'h3A};

  // ****************************************
  // banks, fields and reset values
  // ****************************************
  localparam logic [7:0] BANK_ZERO        = 8'h00;
  localparam logic [7:0] LAST_BANK        = 8'h0A;
  localparam logic [7:0] READ_ZERO        = 8'h00;
  localparam logic [7:0] DIR_RESET        = 8'hFF;
  localparam logic [7:0] PORT_C_DIR_MASK  = 8'hF3;
  localparam logic [7:0] WD_PRESCALE_RST  = 8'h07;
  localparam logic [7:0] FLAGS_KEEP_MASK  = 8'h30;
  localparam logic [7:0] FLAGS_WRITE_MASK = 8'h0F;
  localparam int         FLAG_CARRY       = 0;
  localparam int         FLAG_HALF        = 1;
  localparam int         FLAG_ZERO        = 2;
  localparam int         FLAG_OVER        = 3;
  localparam int         FLAG_PWR_DOWN    = 4;
  localparam int         FLAG_TIMEOUT     = 5;
  localparam int         MASTER_EN_BIT    = 0;
  localparam int         WD_PRE_W         = 7;
  localparam int         WD_CNT_W         = 8;

  typedef enum logic [2:0] {
    OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR, OP_RLC, OP_RRC, OP_PASS
  } alu_op_t;

  typedef enum logic {TBL_IDLE, TBL_WAIT} tbl_state_t;

endpackage

// >>> src/gpr_ram.sv
`timescale 1ns/1ns
module gpr_ram #(
  parameter int NUM_BANKS  = 11,
  parameter int BANK_BYTES = 192
) (
  input logic  clk,
  ram_port_if.mem port
);
  localparam int DEPTH = NUM_BANKS * BANK_BYTES;

  logic [7:0]  mem [DEPTH];
  logic [11:0] idx;

  // flat index; caller keeps bank and offset in range
  assign idx = 12'(int'(port.bank) * BANK_BYTES + int'(port.offset));
  assign port.rdata = mem[idx];

  // plain storage, no reset: contents are undefined at power-up
  always_ff @(posedge clk) begin
    if (port.we) begin
      mem[idx] <= port.wdata;
    end
  end
endmodule

// >>> src/ram_port_if.sv
`timescale 1ns/1ns
interface ram_port_if;
  logic       we;
  logic [3:0] bank;
  logic [7:0] offset;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport ctrl (output we, bank, offset, wdata, input rdata);
  modport mem  (input we, bank, offset, wdata, output rdata);
endinterface

// >>> tb/core_sfr_bank_checker.sv
`timescale 1ns/1ns
module core_sfr_bank_checker
  import core_sfr_pkg::*;
#(
  parameter int NUM_BANKS  = 11,
  parameter int BANK_BYTES = 192
) (
  input logic       clk,
  input logic       rst,
  input logic       acc_valid,
  input logic       acc_write,
  input logic [7:0] acc_addr,
  input logic [7:0] acc_wdata,
  input logic [7:0] rd_data,
  input logic       alu_valid,
  input logic [7:0] flag_register,
  input logic [7:0] bank_select,
  input logic       pc_load,
  input logic [7:0] pc_low_out,
  input logic       dummy_cycle,
  input logic       tbl_read,
  input logic       prog_req,
  input logic       prog_valid,
  input logic       halt_exec,
  input logic       wdt_clear_exec,
  input logic       wdt_reset_req,
  input logic       int_entry,
  input logic       return_from_interrupt_exec,
  input logic       master_interrupt_enable,
  input logic [7:0] port_c_direction
);
  // ****************************************
  // access decode and properties
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // table-store cycles drop requests, so leave them out
  wire store = prog_req && prog_valid;
  wire wr_ok = acc_valid && acc_write && !store;
  wire rd_ok = acc_valid && !acc_write && !store;
  sequence s_pc_write; wr_ok && acc_addr == ADDR_PC_LOW; endsequence
  sequence s_jump;
    pc_load && dummy_cycle ##1 !pc_load && !dummy_cycle;
  endsequence
  sequence s_tbl_start; tbl_read && !prog_req; endsequence
  property p_pc_jump;
    s_pc_write |=> (pc_low_out == $past(acc_wdata)) ##0 s_jump;
  endproperty
  property p_bank_write;
    wr_ok && acc_addr == ADDR_BANK_SEL |=> bank_select == $past(acc_wdata);
  endproperty
  property p_unused_zero;
    rd_ok && acc_addr inside {8'h14, 8'h1C, 8'h1F, 8'h37} |=> rd_data == 8'h00;
  endproperty
  property p_tbl_fetch; s_tbl_start |=> prog_req; endproperty
  property p_tbl_done; store |=> !prog_req; endproperty
  property p_flag_write;
    wr_ok && acc_addr == ADDR_FLAGS && !alu_valid && !halt_exec
      && !wdt_clear_exec && !wdt_reset_req
      |=> flag_register[3:0] == $past(acc_wdata[3:0])
      && flag_register[5:4] == $past(flag_register[5:4]);
  endproperty
  property p_pdf_rise;
    $rose(flag_register[FLAG_PWR_DOWN]) |-> $past(halt_exec);
  endproperty
  property p_pdf_fall;
    $fell(flag_register[FLAG_PWR_DOWN]) |-> $past(wdt_clear_exec) || $past(rst);
  endproperty
  property p_to_rise;
    $rose(flag_register[FLAG_TIMEOUT])
      |-> (wdt_reset_req || $past(wdt_reset_req)) or (##1 wdt_reset_req);
  endproperty
  property p_wdt_pulse; wdt_reset_req |=> !wdt_reset_req; endproperty
  property p_emi;
    int_entry || return_from_interrupt_exec |=> master_interrupt_enable == $past(return_from_interrupt_exec);
  endproperty
  property p_dir_c;
    wr_ok && acc_addr == ADDR_PORT_C_DIR
      |=> port_c_direction == ($past(acc_wdata) & PORT_C_DIR_MASK);
  endproperty
  a_bank_write: assert property (p_bank_write)
    else $error("bank select not loaded");
  a_unused_zero: assert property (p_unused_zero)
    else $error("unused location not zero");
  a_pc_jump: assert property (p_pc_jump)
    else $error("pc low jump wrong");
  a_tbl_fetch: assert property (p_tbl_fetch)
    else $error("table fetch not requested");
  a_tbl_done: assert property (p_tbl_done)
    else $error("table fetch not finished");
  a_flag_write: assert property (p_flag_write)
    else $error("flag write wrong");
  a_pdf_rise: assert property (p_pdf_rise)
    else $error("power down flag set without halt");
  a_pdf_fall: assert property (p_pdf_fall)
    else $error("power down flag cleared wrongly");
  a_to_rise: assert property (p_to_rise)
    else $error("timeout flag set without overflow");
  a_wdt_pulse: assert property (p_wdt_pulse)
    else $error("watchdog reset not a pulse");
  a_emi: assert property (p_emi)
    else $error("master enable wrong");
  a_dir_c: assert property (p_dir_c)
    else $error("port c direction wrong");
endmodule
bind core_sfr_bank core_sfr_bank_checker #(
  .NUM_BANKS (NUM_BANKS),
  .BANK_BYTES(BANK_BYTES)
) u_core_sfr_bank_checker (.*);

// >>> tb/core_sfr_bank_tb_top.sv
`timescale 1ns/1ns
module core_sfr_bank_tb_top;
  import core_sfr_pkg::*;
  logic        clk = 0, rst = 1, power_up = 1, acc_valid = 0, acc_write = 0;
  logic        alu_valid = 0, tbl_read = 0, prog_valid = 0, halt_exec = 0;
  logic        wdt_clear_exec = 0, wdt_tick = 0, int_entry = 0, return_from_interrupt_exec = 0;
  logic        rd_valid, pc_load, dummy_cycle, prog_req, wdt_reset_req;
  logic        master_interrupt_enable, seen_req = 0;
  logic [7:0]  acc_addr = 0, acc_wdata = 0, alu_operand = 0, pc_low_in = 0;
  logic [7:0]  tbl_dest = 0, rd_data, accumulator, flag_register, lo;
  logic [7:0]  bank_select, pc_low_out, prog_addr, port_a_direction;
  logic [7:0]  port_c_direction, port_d_direction, port_e_direction;
  logic [7:0]  port_f_direction, d [11], exp_q [$];
  logic [15:0] prog_data = 0;
  logic [27:0] tv [9] = '{28'hFF01007, 28'h7F0180A, 28'h0505007, 28'h0001FF0,
    28'h8000001, 28'h0100801, 28'hF00F004, 28'h1221330, 28'h5A5A004};
  alu_op_t     alu_op = OP_PASS;
  alu_op_t     ops [9] = '{OP_ADD, OP_ADD, OP_SUB, OP_SUB, OP_RLC, OP_RRC,
                          OP_AND, OP_OR, OP_XOR};
  logic [31:0] seed = 32'h37F57F23;
  int          mismatches = 0, samples_checked = 0;

  core_sfr_bank u_core_sfr_bank (.*);

  // ****************************************
  // clock, helpers and monitor
  // ****************************************
  always #50 clk = ~clk;
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    acc_valid = 1;
    acc_write = w;
    acc_addr = a;
    acc_wdata = v;
    if (!w) exp_q.push_back(v);
    @(negedge clk);
    acc_valid = 0;
  endtask
  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1;
    @(negedge clk);
    s = 0;
  endtask
  task automatic reset_once(input logic pu);
    @(negedge clk);
    rst = 1;
    power_up = pu;
    @(negedge clk);
    rst = 0;
    power_up = 0;
  endtask
  task automatic stop_test();
    $display("compared %0d mismatched %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // oldest expected read is matched against each read answer
  always @(negedge clk) begin
    if (wdt_reset_req === 1'b1) seen_req = 1;
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) check8(rd_data, 8'hXX);
      else check8(rd_data, exp_q.pop_front());
    end
  end
  // a hang costs a mismatch and ends the run
  initial begin
    repeat (6000) @(posedge clk);
    mismatches++;
    stop_test();
  end
  // main sequence, one line printed per test
  initial begin
    repeat (3) @(negedge clk);
    rst = 0;
    power_up = 0;
    acc(0, ADDR_PORT_C_DIR, 8'hF3);
    acc(1, ADDR_PORT_C_DIR, 8'h5C);
    check8(port_c_direction, 8'h50);
    check8(port_a_direction & port_d_direction, 8'hFF);
    check8(port_e_direction & port_f_direction, 8'hFF);
    for (int b = 0; b <= 10; b++) begin
      d[b] = rnd();
      acc(1, ADDR_BANK_SEL, 8'(b));
      acc(1, ADDR_SECOND_PTR, 8'h50);
      acc(1, ADDR_SECOND_IND, d[b]);
      acc(0, ADDR_WD_PRESCALE, 8'h07);
    end
    for (int b = 10; b >= 0; b--) begin
      acc(1, ADDR_BANK_SEL, 8'(b));
      acc(0, ADDR_SECOND_IND, d[b]);
      acc(0, 8'h50, d[0]);
      acc(1, ADDR_FIRST_PTR, 8'h50);
      acc(0, ADDR_FIRST_IND, d[0]);
    end
    acc(1, ADDR_BANK_SEL, 8'h0B);
    acc(1, ADDR_SECOND_IND, 8'h5A);
    acc(0, ADDR_SECOND_IND, 8'h00);
    acc(1, ADDR_BANK_SEL, 8'h01);
    acc(0, ADDR_SECOND_IND, d[1]);
    acc(1, ADDR_SECOND_PTR, ADDR_SECOND_IND);
    acc(1, ADDR_SECOND_IND, 8'h77);
    acc(0, ADDR_SECOND_IND, 8'h00);
    acc(0, 8'h14, 8'h00);
    $display("banking test done");
    pc_low_in = rnd();
    acc(0, ADDR_PC_LOW, pc_low_in);
    acc(1, ADDR_PC_LOW, 8'h3C);
    check8(pc_low_out, 8'h3C);
    acc(1, ADDR_FLAGS, 8'hFF);
    acc(0, ADDR_FLAGS, 8'h0F);
    for (int i = 0; i < 9; i++) begin
      lo = (i < 4) ? 8'h0F : (i < 6) ? 8'h01 : 8'h04;
      acc(1, ADDR_ACCUM, tv[i][27:20]);
      @(negedge clk);
      alu_valid = 1;
      alu_op = ops[i];
      alu_operand = tv[i][19:12];
      @(negedge clk);
      alu_valid = 0;
      check8(accumulator, tv[i][11:4]);
      check8(flag_register & lo, {4'h0, tv[i][3:0]} & lo);
    end
    $display("pc and alu test done");
    acc(1, ADDR_TABLE_PTR, 8'hA5);
    tbl_dest = 8'h60;
    pulse(tbl_read);
    check8(prog_addr, 8'hA5);
    lo = rnd();
    prog_data = {8'hC3, lo};
    pulse(prog_valid);
    acc(0, 8'h60, lo);
    acc(0, ADDR_TABLE_HIGH, 8'hC3);
    acc(1, ADDR_INT_CTRL0, 8'h01);
    pulse(int_entry);
    check8({7'h0, master_interrupt_enable}, 8'h00);
    pulse(return_from_interrupt_exec);
    check8({7'h0, master_interrupt_enable}, 8'h01);
    acc(1, TIMER_LO_ADDR[2], 8'h96);
    acc(0, TIMER_LO_ADDR[2], 8'h96);
    $display("table and interrupt test done");
    acc(1, ADDR_BANK_SEL, 8'h05);
    acc(1, ADDR_WD_PRESCALE, 8'hF9);
    pulse(wdt_clear_exec);
    pulse(halt_exec);
    check8(flag_register & 8'h30, 8'h10);
    repeat (511) pulse(wdt_tick);
    check8({7'h0, seen_req}, 8'h00);
    pulse(wdt_tick);
    repeat (3) @(negedge clk);
    check8({7'h0, seen_req}, 8'h01);
    reset_once(0);
    check8(bank_select, 8'h05);
    check8(flag_register & 8'h30, 8'h30);
    pulse(wdt_clear_exec);
    check8(flag_register & 8'h30, 8'h00);
    reset_once(0);
    check8(bank_select, 8'h00);
    $display("watchdog test done");
    stop_test();
  end
endmodule
